// file: rtl/wake_gate_pkg.sv
// How it works
// - enabled, pending and global enable assert wake
// - disabled source still records status, never wakes
// - port1 enable bits 0-7 gate port1 pins
// - port2 enable bits 0-2,4-7 gate port2 pins
// - port2 enable bit 3 gates grouped smi
// - other resets leave wake enables unchanged
// - standby power-on reset zeroes wake enables
// - status sets on event regardless of enables
// - write one clears status, zero no effect
package wake_gate_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int REG_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_WAKE_STATUS_PORT1 = 6'h01;
    localparam logic [IDX_W-1:0] IDX_WAKE_STATUS_PORT2 = 6'h02;
    localparam logic [IDX_W-1:0] IDX_WAKE_CONTROL = 6'h03;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h04;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h05;
    localparam logic [IDX_W-1:0] IDX_WAKE_ENABLE_PORT1 = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_WAKE_ENABLE_PORT2 = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_WAKE_ENABLE_GROUP4 = 6'h0d;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int GROUPED_SMI_BIT = 3;
    localparam int GLOBAL_WAKE_BIT = 0;
    localparam int IRQ_NEW_STATUS_BIT = 0;
    localparam int IRQ_WAKE_ASSERT_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [REG_W-1:0] WAKE_ENABLE_RESET = 8'h00;
    localparam logic [REG_W-1:0] WAKE_STATUS_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // ----------------------------------------------------------------
    // complete block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] wake_enable_port1;
        logic [REG_W-1:0] wake_enable_port2;
        logic [REG_W-1:0] wake_enable_group4;
        logic [REG_W-1:0] wake_status_port1;
        logic [REG_W-1:0] wake_status_port2;
        logic global_wake_enable;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic wake_output_n;
        logic irq;
        logic awready;
        logic wready;
        logic [IDX_W-1:0] wr_idx;
        logic [REG_W-1:0] wr_data;
        logic wr_strobe;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [REG_W-1:0] rdata;
        logic [1:0] rresp;
    } state_t;

endpackage

// file: rtl/wake_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of asynchronous levels
module wake_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

// file: rtl/wake_gate.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
// wake-enable gating with axi4-lite register access
module wake_gate (
    // clock and standby power-on reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // main-supply, soft and hard reset, active low, asynchronous
    input wire logic i_sys_rst_b,
    // wake sources, active high levels from pins
    input wire logic [7:0] i_port1_pins,
    input wire logic [7:0] i_port2_pins,
    input wire logic i_grouped_smi,
    // wake and interrupt outputs
    output logic o_wake_output_n,
    output logic o_irq,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [wake_gate_pkg::AXI_ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [wake_gate_pkg::AXI_ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    localparam int SYNC_W = 18;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic [7:0] port1_sync;
    logic [7:0] port2_sync;
    logic smi_sync;
    logic sys_rst_sync_b;

    assign sync_in = {i_sys_rst_b, i_grouped_smi, i_port2_pins, i_port1_pins};

    wake_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    // split the synchronised bundle
    assign port1_sync = sync_out[7:0];
    assign port2_sync = sync_out[15:8];
    assign smi_sync = sync_out[16];
    assign sys_rst_sync_b = sync_out[17];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wake_gate_pkg::state_t s_q;
    wake_gate_pkg::state_t s_d;

    logic [7:0] set_port1;
    logic [7:0] set_port2;
    logic [7:0] pend_port1;
    logic [7:0] pend_port2;
    logic wake_any;
    logic wr_fire;
    logic rd_fire;
    logic [wake_gate_pkg::IDX_W-1:0] rd_idx;

    // events seen by the status registers, smi takes the port2 bit 3 slot
    assign set_port1 = port1_sync;
    assign set_port2 = {port2_sync[7:4], smi_sync, port2_sync[2:0]};

    // per-source gating, port2 bit 3 is the grouped smi enable
    assign pend_port1 = s_q.wake_enable_port1 & s_q.wake_status_port1;
    assign pend_port2 = s_q.wake_enable_port2 & s_q.wake_status_port2;
    assign wake_any = s_q.global_wake_enable && ((pend_port1 | pend_port2) != 8'h00);

    // bus handshakes
    assign wr_fire = !s_q.awready && !s_q.wready && !s_q.bvalid;
    assign rd_fire = i_arvalid && s_q.arready;
    assign rd_idx = i_araddr[wake_gate_pkg::AXI_ADDR_W-1:2];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] clr1;
        logic [7:0] clr2;
        logic [wake_gate_pkg::IRQ_W-1:0] clr_irq;
        logic [wake_gate_pkg::IRQ_W-1:0] ev_irq;
        logic wr_ok;
        clr1 = 8'h00;
        clr2 = 8'h00;
        clr_irq = '0;
        ev_irq = '0;
        wr_ok = 1'b0;
        s_d = s_q;

        // write address and data are taken independently
        if (i_awvalid && s_q.awready)
        begin
            s_d.awready = 1'b0;
            s_d.wr_idx = i_awaddr[wake_gate_pkg::AXI_ADDR_W-1:2];
        end
        if (i_wvalid && s_q.wready)
        begin
            s_d.wready = 1'b0;
            s_d.wr_data = i_wdata[7:0];
            s_d.wr_strobe = i_wstrb[0];
        end

        // perform the write once both halves are held
        if (wr_fire)
        begin
            wr_ok = 1'b1;
            unique case (s_q.wr_idx)
                wake_gate_pkg::IDX_WAKE_ENABLE_PORT1:
                begin
                    if (s_q.wr_strobe)
                        s_d.wake_enable_port1 = s_q.wr_data;
                end
                wake_gate_pkg::IDX_WAKE_ENABLE_PORT2:
                begin
                    if (s_q.wr_strobe)
                        s_d.wake_enable_port2 = s_q.wr_data;
                end
                wake_gate_pkg::IDX_WAKE_ENABLE_GROUP4:
                begin
                    if (s_q.wr_strobe)
                        s_d.wake_enable_group4 = s_q.wr_data;
                end
                wake_gate_pkg::IDX_WAKE_STATUS_PORT1:
                begin
                    if (s_q.wr_strobe)
                        clr1 = s_q.wr_data;
                end
                wake_gate_pkg::IDX_WAKE_STATUS_PORT2:
                begin
                    if (s_q.wr_strobe)
                        clr2 = s_q.wr_data;
                end
                wake_gate_pkg::IDX_WAKE_CONTROL:
                begin
                    if (s_q.wr_strobe)
                        s_d.global_wake_enable = s_q.wr_data[wake_gate_pkg::GLOBAL_WAKE_BIT];
                end
                wake_gate_pkg::IDX_IRQ_STATUS:
                begin
                    if (s_q.wr_strobe)
                        clr_irq = s_q.wr_data[wake_gate_pkg::IRQ_W-1:0];
                end
                wake_gate_pkg::IDX_IRQ_MASK:
                begin
                    if (s_q.wr_strobe)
                        s_d.irq_mask = s_q.wr_data[wake_gate_pkg::IRQ_W-1:0];
                end
                default:
                    wr_ok = 1'b0;
            endcase
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? wake_gate_pkg::RESP_OKAY : wake_gate_pkg::RESP_SLVERR;
        end

        // write response accepted, reopen both channels
        if (s_q.bvalid && i_bready)
        begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // read: data registered at the address handshake
        if (rd_fire)
        begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = wake_gate_pkg::RESP_OKAY;
            unique case (rd_idx)
                wake_gate_pkg::IDX_WAKE_ENABLE_PORT1:
                    s_d.rdata = s_q.wake_enable_port1;
                wake_gate_pkg::IDX_WAKE_ENABLE_PORT2:
                    s_d.rdata = s_q.wake_enable_port2;
                wake_gate_pkg::IDX_WAKE_ENABLE_GROUP4:
                    s_d.rdata = s_q.wake_enable_group4;
                wake_gate_pkg::IDX_WAKE_STATUS_PORT1:
                    s_d.rdata = s_q.wake_status_port1;
                wake_gate_pkg::IDX_WAKE_STATUS_PORT2:
                    s_d.rdata = s_q.wake_status_port2;
                wake_gate_pkg::IDX_WAKE_CONTROL:
                    s_d.rdata = {7'h00, s_q.global_wake_enable};
                wake_gate_pkg::IDX_IRQ_STATUS:
                    s_d.rdata = {6'h00, s_q.irq_status};
                wake_gate_pkg::IDX_IRQ_MASK:
                    s_d.rdata = {6'h00, s_q.irq_mask};
                default:
                begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = wake_gate_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && i_rready)
        begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // sticky wake status, a new event wins over a clear
        s_d.wake_status_port1 = (s_q.wake_status_port1 & ~clr1) | set_port1;
        s_d.wake_status_port2 = (s_q.wake_status_port2 & ~clr2) | set_port2;

        // interrupt events: a status bit newly set, the wake output asserting
        ev_irq[wake_gate_pkg::IRQ_NEW_STATUS_BIT] =
            ((set_port1 & ~s_q.wake_status_port1) | (set_port2 & ~s_q.wake_status_port2)) != 8'h00;
        ev_irq[wake_gate_pkg::IRQ_WAKE_ASSERT_BIT] = wake_any && s_q.wake_output_n;

        // system resets touch only the interrupt side, never the wake registers
        if (!sys_rst_sync_b)
        begin
            s_d.irq_mask = wake_gate_pkg::IRQ_RESET;
            clr_irq = '1;
        end
        s_d.irq_status = (s_q.irq_status & ~clr_irq) | ev_irq;

        // registered outputs
        s_d.wake_output_n = !wake_any;
        s_d.irq = (s_q.irq_status & s_q.irq_mask) != '0;
    end

    // ----------------------------------------------------------------
    // state register, cleared only by the standby power-on reset
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_q <= '0;
            s_q.wake_enable_port1 <= wake_gate_pkg::WAKE_ENABLE_RESET;
            s_q.wake_enable_port2 <= wake_gate_pkg::WAKE_ENABLE_RESET;
            s_q.wake_enable_group4 <= wake_gate_pkg::WAKE_ENABLE_RESET;
            s_q.wake_status_port1 <= wake_gate_pkg::WAKE_STATUS_RESET;
            s_q.wake_status_port2 <= wake_gate_pkg::WAKE_STATUS_RESET;
            s_q.irq_mask <= wake_gate_pkg::IRQ_RESET;
            s_q.irq_status <= wake_gate_pkg::IRQ_RESET;
            s_q.wake_output_n <= 1'b1;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_wake_output_n = s_q.wake_output_n;
    assign o_irq = s_q.irq;
    assign o_awready = s_q.awready;
    assign o_wready = s_q.wready;
    assign o_bvalid = s_q.bvalid;
    assign o_bresp = s_q.bresp;
    assign o_arready = s_q.arready;
    assign o_rvalid = s_q.rvalid;
    assign o_rdata = {24'h000000, s_q.rdata};
    assign o_rresp = s_q.rresp;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // port1 source enabled and pending pulls wake low next cycle
    port1_wake_a: assert property (s_q.global_wake_enable && pend_port1 != 8'h00 |=> !o_wake_output_n)
        else $error("enabled port1 source did not assert wake");
    port2_wake_a: assert property (s_q.global_wake_enable && (pend_port2 & 8'hf7) != 8'h00
        |=> !o_wake_output_n)
        else $error("enabled port2 source did not assert wake");
    smi_wake_a: assert property (s_q.global_wake_enable && pend_port2[wake_gate_pkg::GROUPED_SMI_BIT]
        |=> !o_wake_output_n)
        else $error("grouped smi did not assert wake");
    global_gate_a: assert property (!s_q.global_wake_enable |=> o_wake_output_n)
        else $error("wake asserted with global enable off");
    disabled_quiet_a: assert property (pend_port1 == 8'h00 && pend_port2 == 8'h00
        |=> o_wake_output_n)
        else $error("wake asserted with no enabled pending source");
    wake_release_a: assert property (!o_wake_output_n && !wake_any |=> o_wake_output_n)
        else $error("wake not released");
    status_set_a: assert property (set_port1 != 8'h00 || set_port2 != 8'h00
        |=> (s_q.wake_status_port1 & $past(set_port1)) == $past(set_port1)
        && (s_q.wake_status_port2 & $past(set_port2)) == $past(set_port2))
        else $error("wake status missed an event");
    status_hold_a: assert property (!wr_fire |=> (s_q.wake_status_port1 & $past(s_q.wake_status_port1))
        == $past(s_q.wake_status_port1))
        else $error("wake status cleared without a write");
    enable_hold_a: assert property (!wr_fire |=> $stable(s_q.wake_enable_port1)
        && $stable(s_q.wake_enable_port2))
        else $error("wake enable changed without a write");
    bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    irq_level_a: assert property ((s_q.irq_status & s_q.irq_mask) != '0 |=> o_irq)
        else $error("interrupt not raised");

    wake_seen_c: cover property (o_wake_output_n ##1 !o_wake_output_n);
    write_done_c: cover property (o_bvalid && i_bready && o_bresp == wake_gate_pkg::RESP_OKAY);
    read_done_c: cover property (o_rvalid && i_rready);
    irq_seen_c: cover property (!o_irq ##1 o_irq);

endmodule

// file: tb/wake_host_model.sv
`timescale 1ns/1ps
// host-side wake receiver: counts each assertion of the active-low wake line
module wake_host_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // wake line from the block
    input wire logic i_wake_output_n,
    // number of wake assertions seen
    output logic [15:0] o_wake_cnt
);
    logic wake_prev_q;

    // a falling edge of the wake line is one wake request
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wake_prev_q <= 1'b1;
            o_wake_cnt <= 16'h0000;
        end
        else
        begin
            wake_prev_q <= i_wake_output_n;
            if (wake_prev_q && !i_wake_output_n)
            begin
                o_wake_cnt <= o_wake_cnt + 16'h0001;
            end
        end
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // stimulus, responses and register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_ST1 = {wake_gate_pkg::IDX_WAKE_STATUS_PORT1, 2'b00};
    localparam logic [7:0] A_ST2 = {wake_gate_pkg::IDX_WAKE_STATUS_PORT2, 2'b00};
    localparam logic [7:0] A_CTL = {wake_gate_pkg::IDX_WAKE_CONTROL, 2'b00};
    localparam logic [7:0] A_IST = {wake_gate_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_MSK = {wake_gate_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_EN1 = {wake_gate_pkg::IDX_WAKE_ENABLE_PORT1, 2'b00};
    localparam logic [7:0] A_EN2 = {wake_gate_pkg::IDX_WAKE_ENABLE_PORT2, 2'b00};
    localparam logic [7:0] A_EN4 = {wake_gate_pkg::IDX_WAKE_ENABLE_GROUP4, 2'b00};
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_sys_rst_b = 1'b1;
    logic [7:0] i_port1_pins = 8'h00;
    logic [7:0] i_port2_pins = 8'h00;
    logic i_grouped_smi = 1'b0;
    logic i_awvalid = 1'b0;
    logic [7:0] i_awaddr = 8'h00;
    logic i_wvalid = 1'b0;
    logic [31:0] i_wdata = 32'h00000000;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic [7:0] i_araddr = 8'h00;
    logic i_rready = 1'b0;
    logic o_wake_output_n, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [15:0] wake_cnt;
    int error_cnt = 0;
    int total_checks = 0;

    always #25 i_clk = ~i_clk;

    wake_gate u_wake_gate (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sys_rst_b(i_sys_rst_b),
        .i_port1_pins(i_port1_pins), .i_port2_pins(i_port2_pins), .i_grouped_smi(i_grouped_smi),
        .o_wake_output_n(o_wake_output_n), .o_irq(o_irq), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
        .i_wstrb(4'hf), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));

    wake_host_model u_wake_host_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_wake_output_n(o_wake_output_n), .o_wake_cnt(wake_cnt));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tmo;
        error_cnt++;
        $display("[FAIL] %0t bus answer timed out", $time);
        report_and_stop;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // axi4-lite write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge i_clk);
            if (aw && w && o_bvalid)
            begin
                r = o_bresp;
                i_bready <= 1'b0;
                break;
            end
            if (!aw && o_awready)
            begin
                aw = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (!w && o_wready)
            begin
                w = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        if (n == 40)
            tmo;
    endtask

    // axi4-lite read: rready held until rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar;
        ar = 1'b0;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge i_clk);
            if (ar && o_rvalid)
            begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                break;
            end
            if (!ar && o_arready)
            begin
                ar = 1'b1;
                i_arvalid <= 1'b0;
            end
        end
        if (n == 40)
            tmo;
    endtask

    task automatic w1(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(r, wake_gate_pkg::RESP_OKAY, "write response");
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(r, wake_gate_pkg::RESP_OKAY, "read response");
        chk(d, exp, "read data");
    endtask

    // drive sources against one enable value, check wake, then tidy up
    task automatic wake_case(input logic [7:0] ea, input logic [7:0] en, input logic [7:0] a,
        input logic [7:0] b, input logic s, input logic exp_n);
        w1(ea, en);
        i_port1_pins <= a;
        i_port2_pins <= b;
        i_grouped_smi <= s;
        tick(6);
        chk(o_wake_output_n, exp_n, "wake level");
        i_port1_pins <= 8'h00;
        i_port2_pins <= 8'h00;
        i_grouped_smi <= 1'b0;
        tick(4);
        w1(A_ST1, 32'h000000ff);
        w1(A_ST2, 32'h000000ff);
        w1(ea, 32'h00000000);
        tick(3);
        chk(o_wake_output_n, 1'b1, "wake release");
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rchk(A_EN1, 32'h0);
        rchk(A_EN2, 32'h0);
        rchk(A_EN4, 32'h0);
        w1(A_EN4, 32'h5a);
        rchk(A_EN4, 32'h5a);
        w1(A_EN4, 32'h0);
        wr(8'h3c, 32'hff, r);
        chk(r, wake_gate_pkg::RESP_SLVERR, "unmapped write");
        rd(8'h3c, d, r);
        chk(r, wake_gate_pkg::RESP_SLVERR, "unmapped read");
        chk(d, 32'h0, "unmapped data");
        $display("test reset done");
    endtask

    task automatic t_ports;
        for (int n = 0; n < 8; n++)
        begin
            wake_case(A_EN1, 8'h01 << n, ~(8'h01 << n), 8'h00, 1'b0, 1'b1);
            wake_case(A_EN1, 8'h01 << n, 8'h01 << n, 8'h00, 1'b0, 1'b0);
            if (n != 3)
            begin
                wake_case(A_EN2, 8'h01 << n, 8'h00, ~(8'h01 << n), 1'b1, 1'b1);
                wake_case(A_EN2, 8'h01 << n, 8'h00, 8'h01 << n, 1'b0, 1'b0);
            end
        end
        wake_case(A_EN2, 8'h08, 8'h00, 8'h08, 1'b0, 1'b1);
        wake_case(A_EN2, 8'h08, 8'h00, 8'h00, 1'b1, 1'b0);
        wake_case(A_EN2, 8'hf7, 8'h00, 8'h00, 1'b1, 1'b1);
        w1(A_CTL, 32'h0);
        wake_case(A_EN1, 8'hff, 8'hff, 8'h00, 1'b0, 1'b1);
        w1(A_CTL, 32'h1);
        $display("test ports done");
    endtask

    task automatic t_status;
        i_port1_pins <= 8'h5a;
        i_grouped_smi <= 1'b1;
        tick(5);
        i_port1_pins <= 8'h00;
        i_grouped_smi <= 1'b0;
        tick(4);
        rchk(A_ST1, 32'h5a);
        rchk(A_ST2, 32'h08);
        w1(A_ST1, 32'h00);
        rchk(A_ST1, 32'h5a);
        w1(A_ST1, 32'h0a);
        rchk(A_ST1, 32'h50);
        w1(A_ST1, 32'hff);
        w1(A_ST2, 32'hff);
        $display("test status done");
    endtask

    task automatic t_or;
        int base;
        base = wake_cnt;
        w1(A_IST, 32'h03);
        w1(A_EN1, 32'h03);
        i_port1_pins <= 8'h03;
        tick(6);
        chk(o_wake_output_n, 1'b0, "wake on two sources");
        i_port1_pins <= 8'h02;
        tick(3);
        w1(A_ST1, 32'h01);
        tick(3);
        chk(o_wake_output_n, 1'b0, "wake held by one");
        i_port1_pins <= 8'h00;
        tick(3);
        w1(A_ST1, 32'h02);
        tick(3);
        chk(o_wake_output_n, 1'b1, "wake released");
        chk(wake_cnt, base + 1, "host wake count");
        rchk(A_IST, 32'h03);
        w1(A_EN1, 32'h00);
        $display("test or done");
    endtask

    task automatic t_irq;
        w1(A_IST, 32'h03);
        w1(A_MSK, 32'h01);
        tick(2);
        chk(o_irq, 1'b0, "irq idle");
        i_port1_pins <= 8'h10;
        tick(5);
        i_port1_pins <= 8'h00;
        tick(4);
        chk(o_irq, 1'b1, "irq raised");
        w1(A_MSK, 32'h00);
        tick(2);
        chk(o_irq, 1'b0, "irq masked");
        w1(A_MSK, 32'h01);
        tick(2);
        chk(o_irq, 1'b1, "irq unmasked");
        w1(A_IST, 32'h01);
        tick(2);
        chk(o_irq, 1'b0, "irq cleared");
        w1(A_ST1, 32'hff);
        $display("test irq done");
    endtask

    task automatic t_resets;
        w1(A_EN1, 32'ha5);
        w1(A_EN2, 32'h3c);
        i_sys_rst_b <= 1'b0;
        tick(4);
        i_sys_rst_b <= 1'b1;
        tick(4);
        rchk(A_EN1, 32'ha5);
        rchk(A_EN2, 32'h3c);
        i_rst_b <= 1'b0;
        tick(2);
        i_rst_b <= 1'b1;
        rchk(A_EN1, 32'h00);
        rchk(A_EN2, 32'h00);
        $display("test resets done");
    endtask

    // main sequence
    initial
    begin
        tick(2);
        i_rst_b <= 1'b1;
        t_reset;
        w1(A_CTL, 32'h1);
        t_ports;
        t_status;
        t_or;
        t_irq;
        t_resets;
        report_and_stop;
    end
endmodule
